// [hdl/frmx_core.sv]
/*
  frmx_core: executes or_acc_into_file, move_file_value and
  store_acc_to_file, one instruction per cycle.
  assumes: file array reads combinationally at file_raddr_out and
  writes on the clock edge when the write strobe is high.
  a read of the address written by the previous instruction is
  served from the pending write, since that write lands one edge late.
*/
// Operation
// - decode 00_0100_dfff_ffff as accumulator OR file
// - OR result to accumulator or file
// - OR sets zero flag on zero result
// - decode 00_1000_dfff_ffff as move file
// - move loads accumulator or rewrites file
// - move updates zero flag either destination
// - decode 00_0000_1fff_ffff as store, no flags
`timescale 1ns/1ps
module frmx_core
  import frmx_pkg::*;
(
  input  wire logic              core_clk_in,
  input  wire logic              rst_b_in,
  input  wire logic [INSN_W-1:0] insn_in,
  input  wire logic              insn_valid_in,
  input  wire logic [DATA_W-1:0] file_rdata_in,
  output logic [ADDR_W-1:0]      file_raddr_out,
  output logic                   file_we_out,
  output logic [ADDR_W-1:0]      file_waddr_out,
  output logic [DATA_W-1:0]      file_wdata_out,
  output logic [DATA_W-1:0]      acc_out,
  output logic                   zero_out,
  output logic                   done_out
);

  frmx_dec_s dec_w;

  frmx_decode u_dec (
    .insn_in  (insn_in),
    .valid_in (insn_valid_in),
    .dec_out  (dec_w)
  );

  logic [DATA_W-1:0] acc_reg;
  logic [DATA_W-1:0] acc_next;
  logic              zero_reg;
  logic              zero_next;
  frmx_wr_s          wr_reg;
  frmx_wr_s          wr_next;
  logic              done_reg;

  assign file_raddr_out = dec_w.addr;

  // pending write bypass
  // the array sees a write one edge late; forward it to a
  // back-to-back reader of the same address
  wire logic              fwd_hit_w = wr_reg.we && (wr_reg.addr == dec_w.addr);
  wire logic [DATA_W-1:0] rd_w      = fwd_hit_w ? wr_reg.data : file_rdata_in;

  wire logic [DATA_W-1:0] or_w = acc_reg | rd_w;

  wire logic is_or_w    = (dec_w.op == FRMX_OP_OR);
  wire logic is_move_w  = (dec_w.op == FRMX_OP_MOVE);
  wire logic is_store_w = (dec_w.op == FRMX_OP_STORE);

  wire logic [DATA_W-1:0] res_w    = is_or_w ? or_w : rd_w;
  wire logic              to_acc_w = (is_or_w || is_move_w) && !dec_w.dest_file;
  wire logic              to_file_w = ((is_or_w || is_move_w) && dec_w.dest_file)
                                      || is_store_w;

  assign acc_next = to_acc_w ? res_w : acc_reg;

  assign zero_next = (is_or_w || is_move_w) ? (res_w == '0) : zero_reg;

  assign wr_next.we   = to_file_w;
  assign wr_next.addr = dec_w.addr;
  assign wr_next.data = is_store_w ? acc_reg : res_w;

  always_ff @(posedge core_clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      acc_reg  <= ACC_RST;
      zero_reg <= ZERO_RST;
      wr_reg   <= '0;
      done_reg <= 1'b0;
    end else begin
      acc_reg  <= acc_next;
      zero_reg <= zero_next;
      wr_reg   <= wr_next;
      done_reg <= (dec_w.op != FRMX_OP_NONE);
    end
  end

  assign file_we_out    = wr_reg.we;
  assign file_waddr_out = wr_reg.addr;
  assign file_wdata_out = wr_reg.data;
  assign acc_out        = acc_reg;
  assign zero_out       = zero_reg;
  assign done_out       = done_reg;

  default clocking cb @(posedge core_clk_in); endclocking
  default disable iff (!rst_b_in);

  // datapath checks
  or_to_acc_a: assert property (
    is_or_w && !dec_w.dest_file |=> acc_reg == $past(or_w) && !file_we_out)
    else $error("or to accumulator wrong");

  or_to_file_a: assert property (
    is_or_w && dec_w.dest_file |=> file_we_out && file_wdata_out == $past(or_w)
      && acc_reg == $past(acc_reg))
    else $error("or to file wrong");

  or_zero_a: assert property (
    is_or_w |=> zero_reg == ($past(or_w) == 8'h00))
    else $error("or zero flag wrong");

  move_acc_a: assert property (
    is_move_w && !dec_w.dest_file |=> acc_reg == $past(rd_w))
    else $error("move to accumulator wrong");

  move_zero_a: assert property (
    is_move_w |=> zero_reg == ($past(rd_w) == 8'h00))
    else $error("move zero flag wrong");

  store_file_a: assert property (
    is_store_w |=> file_we_out && file_wdata_out == $past(acc_reg)
      && file_waddr_out == $past(dec_w.addr) && $stable(zero_reg) && $stable(acc_reg))
    else $error("store wrong");

  store_decode_a: assert property (
    insn_valid_in && insn_in[13:7] == 7'h01 |-> is_store_w)
    else $error("store not decoded");

  idle_quiet_a: assert property (
    dec_w.op == FRMX_OP_NONE |=> !file_we_out && !done_out && $stable(acc_reg)
      && $stable(zero_reg))
    else $error("idle cycle changed state");

  one_cycle_a: assert property (
    dec_w.op != FRMX_OP_NONE |=> done_out)
    else $error("not done in one cycle");

  or_waddr_a: assert property (
    is_or_w && dec_w.dest_file
    |=> file_waddr_out == $past(dec_w.addr))
    else $error("or write address wrong");

  move_file_a: assert property (
    is_move_w && dec_w.dest_file
    |=> file_we_out
      && file_wdata_out == $past(rd_w)
      && file_waddr_out == $past(dec_w.addr)
      && acc_reg == $past(acc_reg))
    else $error("move to file wrong");

  move_acc_quiet_a: assert property (
    is_move_w && !dec_w.dest_file
    |=> !file_we_out)
    else $error("move to accumulator wrote the file");

  acc_hold_a: assert property (
    !to_acc_w
    |=> acc_reg == $past(acc_reg))
    else $error("accumulator changed without accumulator destination");

  we_only_a: assert property (
    !to_file_w
    |=> !file_we_out)
    else $error("file written without file destination");

  zero_only_a: assert property (
    !is_or_w && !is_move_w
    |=> zero_reg == $past(zero_reg))
    else $error("zero flag changed by other instruction");

  done_valid_a: assert property (
    !insn_valid_in
    |=> !done_out)
    else $error("done without a valid word");

  // decode checks
  or_decode_a: assert property (
    insn_valid_in && insn_in[OPC_MSB:OPC_LSB] == OPC_OR_ACC
    |-> is_or_w)
    else $error("or not decoded");

  move_decode_a: assert property (
    insn_valid_in && insn_in[OPC_MSB:OPC_LSB] == OPC_MOVE_FILE
    |-> is_move_w)
    else $error("move not decoded");

  store_refuse_a: assert property (
    insn_valid_in && insn_in[OPC_MSB:OPC_LSB] == OPC_STORE_ACC && !insn_in[DEST_BIT]
    |-> dec_w.op == FRMX_OP_NONE)
    else $error("clear bit seven taken as store");

  invalid_quiet_a: assert property (
    !insn_valid_in
    |-> dec_w.op == FRMX_OP_NONE)
    else $error("operation decoded without valid");

  // hazard checks
  raddr_a: assert property (
    insn_valid_in
    |-> file_raddr_out == insn_in[ADDR_W-1:0])
    else $error("file read address wrong");

  fwd_a: assert property (
    file_we_out && file_waddr_out == file_raddr_out
    |-> rd_w == file_wdata_out)
    else $error("pending write not forwarded");

  // main scenarios
  or_file_c:    cover property (is_or_w && dec_w.dest_file);
  move_zero_c:  cover property (is_move_w && rd_w == 8'h00);
  store_c:      cover property (is_store_w ##1 is_or_w);
  move_file_c:  cover property (is_move_w && dec_w.dest_file && dec_w.addr == 7'h7f);
  fwd_c:        cover property (fwd_hit_w && is_or_w);

endmodule

// [hdl/frmx_pkg.sv]
/*
  frmx_pkg: shared constants and carriers for the file-register
  or/move/store execute block.
  assumes: 14-bit instruction words, 8-bit data, 7-bit file address.
*/
package frmx_pkg;

  localparam int INSN_W = 14;
  localparam int DATA_W = 8;
  localparam int ADDR_W = 7;

  // opcode field positions and values
  localparam int OPC_MSB = 13;
  localparam int OPC_LSB = 8;
  localparam int DEST_BIT = 7;
  localparam logic [5:0] OPC_OR_ACC = 6'h04;
  localparam logic [5:0] OPC_MOVE_FILE = 6'h08;
  localparam logic [5:0] OPC_STORE_ACC = 6'h00;

  localparam logic [DATA_W-1:0] ACC_RST = 8'h00;
  localparam logic ZERO_RST = 1'b0;

  typedef enum logic [1:0] {
    FRMX_OP_NONE,
    FRMX_OP_OR,
    FRMX_OP_MOVE,
    FRMX_OP_STORE
  } frmx_op_e;

  typedef struct packed {
    frmx_op_e            op;
    logic                dest_file;
    logic [ADDR_W-1:0]   addr;
  } frmx_dec_s;

  typedef struct packed {
    logic                we;
    logic [ADDR_W-1:0]   addr;
    logic [DATA_W-1:0]   data;
  } frmx_wr_s;

endpackage

// [hdl/frmx_decode.sv]
/*
  frmx_decode: combinational decode of one instruction word.
  assumes: word is valid when the caller says so.
*/
`timescale 1ns/1ps
module frmx_decode
  import frmx_pkg::*;
(
  input  wire logic [INSN_W-1:0] insn_in,
  input  wire logic              valid_in,
  output frmx_dec_s              dec_out
);

  wire logic [5:0] opc_w = insn_in[OPC_MSB:OPC_LSB];
  wire logic       d_w   = insn_in[DEST_BIT];

  wire logic is_or_w    = valid_in && (opc_w == OPC_OR_ACC);
  wire logic is_move_w  = valid_in && (opc_w == OPC_MOVE_FILE);
  wire logic is_store_w = valid_in && (opc_w == OPC_STORE_ACC) && d_w;

  assign dec_out.op = is_or_w    ? FRMX_OP_OR :
                      is_move_w  ? FRMX_OP_MOVE :
                      is_store_w ? FRMX_OP_STORE : FRMX_OP_NONE;
  assign dec_out.dest_file = d_w;
  assign dec_out.addr      = insn_in[ADDR_W-1:0];

endmodule

// [sim/frmx_file_model.sv]
/* frmx_file_model: 128-byte file array with combinational read.
   assumes: the core writes on the clock edge while its strobe is high. */
`timescale 1ns/1ps
module frmx_file_model
  import frmx_pkg::*;
(
  input  wire logic              core_clk_in,
  input  wire logic              we_in,
  input  wire logic [ADDR_W-1:0] waddr_in,
  input  wire logic [DATA_W-1:0] wdata_in,
  input  wire logic [ADDR_W-1:0] raddr_in,
  output logic [DATA_W-1:0]      rdata_out
);
  logic [DATA_W-1:0] mem_reg [128];
  // preset: address xor 5a, so 5a holds zero
  initial begin
    for (int i = 0; i < 128; i++) begin
      mem_reg[i] = 8'(i) ^ 8'h5a;
    end
  end
  assign rdata_out = mem_reg[raddr_in];
  always @(posedge core_clk_in) begin
    if (we_in) begin
      mem_reg[waddr_in] <= wdata_in;
    end
  end
endmodule

// [sim/tb_top.sv]
/* tb_top: directed tests of frmx_core against the file array model.
   assumes: mostly one idle cycle between instructions, one back-to-back pair. */
`timescale 1ns/1ps
module tb_top
  import frmx_pkg::*;
;
  logic              core_clk_in = 0;
  logic              rst_b_in = 0;
  logic [INSN_W-1:0] insn = '0;
  logic              valid = 0;
  logic [DATA_W-1:0] rdata, wdata, acc;
  logic [ADDR_W-1:0] raddr, waddr;
  logic              we, zero, done;
  int                failures = 0;
  int                check_count = 0;
  always #10 core_clk_in = ~core_clk_in;
  frmx_core dut (.core_clk_in(core_clk_in), .rst_b_in(rst_b_in), .insn_in(insn),
    .insn_valid_in(valid), .file_rdata_in(rdata), .file_raddr_out(raddr),
    .file_we_out(we), .file_waddr_out(waddr), .file_wdata_out(wdata),
    .acc_out(acc), .zero_out(zero), .done_out(done));
  frmx_file_model files (.core_clk_in(core_clk_in), .we_in(we), .waddr_in(waddr),
    .wdata_in(wdata), .raddr_in(raddr), .rdata_out(rdata));
  task chk(input string n, input logic [7:0] e, input logic [7:0] g);
    check_count++;
    if (g !== e) begin
      failures++;
      $display("[FAIL] %s expected %h seen %h", n, e, g);
    end
  endtask
  task exec(input logic [INSN_W-1:0] w);
    @(posedge core_clk_in) #1 insn = w;
    valid = 1;
    @(posedge core_clk_in) #1 valid = 0;
  endtask
  task post(input logic [7:0] a, input logic w, input logic z, input logic d);
    chk("acc", a, acc);
    chk("we", {7'h0, w}, {7'h0, we});
    chk("zero", {7'h0, z}, {7'h0, zero});
    chk("done", {7'h0, d}, {7'h0, done});
  endtask
  task wr(input logic [6:0] a, input logic [7:0] d);
    chk("waddr", {1'b0, a}, {1'b0, waddr});
    chk("wdata", d, wdata);
  endtask
  task t_move;
    exec(14'h0811);
    post(8'h4b, 0, 0, 1);
    exec(14'h085a);
    post(8'h00, 0, 1, 1);
    $display("test move done");
  endtask
  task t_or;
    exec(14'h045a);
    post(8'h00, 0, 1, 1);
    exec(14'h0413);
    post(8'h49, 0, 0, 1);
    exec(14'h04ff);
    post(8'h49, 1, 0, 1);
    wr(7'h7f, 8'h6d);
    $display("test or done");
  endtask
  task t_store;
    exec(14'h08da);
    post(8'h49, 1, 1, 1);
    wr(7'h5a, 8'h00);
    exec(14'h0080);
    post(8'h49, 1, 1, 1);
    wr(7'h00, 8'h49);
    exec(14'h087f);
    post(8'h6d, 0, 0, 1);
    $display("test store done");
  endtask
  task t_refuse;
    exec(14'h0013);
    post(8'h6d, 0, 0, 0);
    $display("test refuse done");
  endtask
  task t_b2b;
    @(posedge core_clk_in) #1 insn = 14'h00a2;
    valid = 1;
    @(posedge core_clk_in) #1 insn = 14'h0422;
    post(8'h6d, 1, 0, 1);
    wr(7'h22, 8'h6d);
    @(posedge core_clk_in) #1 valid = 0;
    post(8'h6d, 0, 0, 1);
    chk("raddr", 8'h22, {1'b0, raddr});
    $display("test back to back done");
  endtask
  task stop_test;
    $display("checks %0d failures %0d", check_count, failures);
    if (failures == 0 && check_count > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask
  initial begin
    repeat (8) @(posedge core_clk_in);
    #1 rst_b_in = 1;
    t_move;
    t_or;
    t_store;
    t_refuse;
    t_b2b;
    stop_test;
  end
  initial begin
    #20000;
    failures++;
    stop_test;
  end
endmodule
